/* File: qpio_pkg.sv */
package qpio_pkg;
    // ========================================
    // Register addresses
    localparam logic [15:0] ADDR_PORT0_DATA = 16'hff00;
    localparam logic [15:0] ADDR_PORT1_DATA = 16'hff01;
    localparam logic [15:0] ADDR_PORT2_DATA = 16'hff02;
    localparam logic [15:0] ADDR_PORT4_DATA = 16'hff04;
    localparam logic [15:0] ADDR_PORT0_DIRECTION = 16'hff20;
    localparam logic [15:0] ADDR_PORT1_DIRECTION = 16'hff21;
    localparam logic [15:0] ADDR_PORT2_DIRECTION = 16'hff22;
    localparam logic [15:0] ADDR_PORT4_DIRECTION = 16'hff24;
    localparam logic [15:0] ADDR_PORT01_OUTPUT_TYPE = 16'hff30;
    localparam logic [15:0] ADDR_PORT2_PIN_OUTPUT_TYPE = 16'hff31;
    localparam logic [15:0] ADDR_PULLUP_ENABLE = 16'hfff7;
    localparam logic [15:0] ADDR_KEY_RETURN_MODE = 16'hff50;
    // ========================================
    // Reset values
    localparam logic [7:0] RST_DIRECTION = 8'hff;
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic [7:0] RST_OUTPUT_TYPE = 8'h00;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_KEY_RETURN = 8'h00;
    // ========================================
    // Writable masks and field positions
    localparam logic [7:0] MASK_PORT2_DIR = 8'h7f;
    localparam logic [7:0] MASK_PULLUP = 8'h17;
    localparam logic [7:0] MASK_PORT01_TYPE = 8'h03;
    localparam logic [7:0] MASK_PORT2_TYPE = 8'h60;
    localparam logic [7:0] MASK_KEY_RETURN = 8'h01;
    localparam int POS_PU_PORT0 = 0;
    localparam int POS_PU_PORT1 = 1;
    localparam int POS_PU_PORT2 = 2;
    localparam int POS_PU_PORT4 = 4;
    localparam int POS_TYPE_PORT0 = 0;
    localparam int POS_TYPE_PORT1 = 1;
    localparam int POS_TYPE_PIN6 = 6;
    localparam int PORT_WIDTH = 8;
    localparam int PORT2_WIDTH = 7;
    localparam int PIN_TOTAL = 31;
endpackage

/* File: qpio_pin_sync.sv */
`timescale 1ns/1ps
module qpio_pin_sync
    import qpio_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    // ========================================
    // Three stages; level moves once stages two and three agree
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [WIDTH-1:0] s1_d, s2_d, s3_d, lvl_d;

    generate
        if (WIDTH < 1) begin : g_bad
            $error("qpio_pin_sync: WIDTH must be positive");
        end
    endgenerate

    always_comb begin
        s1_d = pin_in;
        s2_d = s1_q;
        s3_d = s2_q;
        lvl_d = lvl_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;
endmodule // qpio_pin_sync

/* File: qpio_port_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// [R1] Thirty-one pins in four ports, each with output latch and direction.
// [R2] Direction 0 drives the pin; direction 1 makes it an input.
// [R3] Reset loads all direction registers with ones: every pin input.
// [R4] Direction, pull-up, output-type registers take bit or byte writes.
// [R5] Pull-up only when port enable set and pin is input.
// [R6] Pull-up bit m serves whole port m for ports 0,1,2,4.
// [R7] Pull-up enable register clears to zero on reset.
// [R8] Software writes zero to pull-up bits 3 and 5 to 7.
// [R9] Ports 0 and 1 each pick push-pull or open-drain together.
// [R10] Port 2 pins 5 and 6 alone pick output type per pin.
// [R11] Timer output on port 2 pin 6 needs direction and latch zero.
// [R12] Key-return use needs port 4 input and key-return enable set.
// [R13] Driven level change on port 2 pin 6 raises interrupt request.
// [R14] Software sets port 2 direction and latch for alternate functions.
// [R15] Port read returns pin levels, leaving output latch unchanged.
// [R16] Writes in input mode update latch; pin stays undriven.
// [R17] Output type 0 push-pull, 1 open-drain; both clear on reset.
// [R18] Open-drain drives low for latch 0, releases for latch 1.
// [R19] Port 2 direction top bit reads one and ignores writes.
module qpio_port_ctrl
    import qpio_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic [15:0] bus_addr_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire logic [7:0] bus_bit_mask_in,
    input wire logic [7:0] bus_wdata_in,
    output logic [7:0] bus_rdata_out,
    input wire logic [7:0] port0_pin_in,
    input wire logic [7:0] port1_pin_in,
    input wire logic [6:0] port2_pin_in,
    input wire logic [7:0] port4_pin_in,
    output logic [7:0] port0_pin_out,
    output logic [7:0] port1_pin_out,
    output logic [6:0] port2_pin_out,
    output logic [7:0] port4_pin_out,
    output logic [7:0] port0_pin_oe_n_out,
    output logic [7:0] port1_pin_oe_n_out,
    output logic [6:0] port2_pin_oe_n_out,
    output logic [7:0] port4_pin_oe_n_out,
    output logic [PIN_TOTAL-1:0] pullup_on_out,
    output logic key_return_mode_enable_out,
    output logic port2_pin6_edge_out
);
    // ========================================
    // Register state
    logic [7:0] lat0_q, lat1_q, lat2_q, lat4_q;
    logic [7:0] lat0_d, lat1_d, lat2_d, lat4_d;
    logic [7:0] dir0_q, dir1_q, dir2_q, dir4_q;
    logic [7:0] dir0_d, dir1_d, dir2_d, dir4_d;
    logic [7:0] pu_q, pu_d, ty01_q, ty01_d, ty2_q, ty2_d, krm_q, krm_d;
    logic [7:0] lvl0, lvl1, lvl4;
    logic [6:0] lvl2;

    // Bit or byte write: only masked bits change
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wd,
                                         input logic [7:0] bm,
                                         input logic [7:0] keep);
        merge = ((old & ~bm) | (wd & bm)) & keep;
    endfunction

    function automatic logic hit(input logic [15:0] a);
        hit = bus_wr_in && (bus_addr_in == a);
    endfunction

    // ========================================
    // Pin synchronisers
    qpio_pin_sync #(.WIDTH(8)) u_sync0 (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .pin_in(port0_pin_in), .level_out(lvl0));
    qpio_pin_sync #(.WIDTH(8)) u_sync1 (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .pin_in(port1_pin_in), .level_out(lvl1));
    qpio_pin_sync #(.WIDTH(7)) u_sync2 (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .pin_in(port2_pin_in), .level_out(lvl2));
    qpio_pin_sync #(.WIDTH(8)) u_sync4 (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .pin_in(port4_pin_in), .level_out(lvl4));

    // ========================================
    // Register writes
    always_comb begin
        lat0_d = lat0_q;
        lat1_d = lat1_q;
        lat2_d = lat2_q;
        lat4_d = lat4_q;
        dir0_d = dir0_q;
        dir1_d = dir1_q;
        dir2_d = dir2_q;
        dir4_d = dir4_q;
        pu_d = pu_q;
        ty01_d = ty01_q;
        ty2_d = ty2_q;
        krm_d = krm_q;
        // Latches written in any mode [R16]
        if (hit(ADDR_PORT0_DATA)) lat0_d = merge(lat0_q, bus_wdata_in,
            bus_bit_mask_in, 8'hff);
        if (hit(ADDR_PORT1_DATA)) lat1_d = merge(lat1_q, bus_wdata_in,
            bus_bit_mask_in, 8'hff);
        if (hit(ADDR_PORT2_DATA)) lat2_d = merge(lat2_q, bus_wdata_in,
            bus_bit_mask_in, MASK_PORT2_DIR);
        if (hit(ADDR_PORT4_DATA)) lat4_d = merge(lat4_q, bus_wdata_in,
            bus_bit_mask_in, 8'hff);
        if (hit(ADDR_PORT0_DIRECTION)) dir0_d = merge(dir0_q, bus_wdata_in,
            bus_bit_mask_in, 8'hff); // [R4]
        if (hit(ADDR_PORT1_DIRECTION)) dir1_d = merge(dir1_q, bus_wdata_in,
            bus_bit_mask_in, 8'hff); // [R4]
        if (hit(ADDR_PORT2_DIRECTION)) dir2_d = merge(dir2_q, bus_wdata_in,
            bus_bit_mask_in, MASK_PORT2_DIR) | ~MASK_PORT2_DIR; // [R19]
        if (hit(ADDR_PORT4_DIRECTION)) dir4_d = merge(dir4_q, bus_wdata_in,
            bus_bit_mask_in, 8'hff); // [R4]
        if (hit(ADDR_PULLUP_ENABLE)) pu_d = merge(pu_q, bus_wdata_in,
            bus_bit_mask_in, MASK_PULLUP); // [R4]
        if (hit(ADDR_PORT01_OUTPUT_TYPE)) ty01_d = merge(ty01_q,
            bus_wdata_in, bus_bit_mask_in, MASK_PORT01_TYPE); // [R9]
        if (hit(ADDR_PORT2_PIN_OUTPUT_TYPE)) ty2_d = merge(ty2_q,
            bus_wdata_in, bus_bit_mask_in, MASK_PORT2_TYPE); // [R10]
        if (hit(ADDR_KEY_RETURN_MODE)) krm_d = merge(krm_q, bus_wdata_in,
            bus_bit_mask_in, MASK_KEY_RETURN);
    end

    // ========================================
    // Pin drive, pull-ups, read data, port 2 pin 6 edge
    logic [7:0] drv0_d, drv1_d, drv4_d, oen0_d, oen1_d, oen4_d;
    logic [6:0] drv2_d, oen2_d;
    logic [PIN_TOTAL-1:0] pu_on_d;
    logic [7:0] rdata_d;
    logic edge_d;
    logic [7:0] drv0_q, drv1_q, drv4_q, oen0_q, oen1_q, oen4_q;
    logic [6:0] drv2_q, oen2_q;
    logic [PIN_TOTAL-1:0] pu_on_q;
    logic [7:0] rdata_q;
    logic edge_q, p26_drv_prev_q, p26_drv_prev_d;

    always_comb begin
        // Push-pull drives latch; open-drain drives only a zero [R18]
        for (int i = 0; i < PORT_WIDTH; i++) begin
            drv0_d[i] = lat0_q[i];
            oen0_d[i] = dir0_q[i] |
                (ty01_q[POS_TYPE_PORT0] & lat0_q[i]); // [R2] [R9] [R17]
            drv1_d[i] = lat1_q[i];
            oen1_d[i] = dir1_q[i] |
                (ty01_q[POS_TYPE_PORT1] & lat1_q[i]); // [R2] [R9] [R17]
            drv4_d[i] = lat4_q[i];
            oen4_d[i] = dir4_q[i]; // [R2]
        end
        for (int i = 0; i < PORT2_WIDTH; i++) begin
            drv2_d[i] = lat2_q[i];
            oen2_d[i] = dir2_q[i] | (ty2_q[i] & lat2_q[i]); // [R10] [R17]
        end
        // Pull-ups only on input pins, one enable per port [R5] [R6]
        pu_on_d = {dir4_q & {8{pu_q[POS_PU_PORT4]}},
                   dir2_q[6:0] & {7{pu_q[POS_PU_PORT2]}},
                   dir1_q & {8{pu_q[POS_PU_PORT1]}},
                   dir0_q & {8{pu_q[POS_PU_PORT0]}}}; // [R1]
        // Driven level change on pin 6 flags interrupt request [R13]
        p26_drv_prev_d = lat2_q[POS_TYPE_PIN6];
        edge_d = !dir2_q[POS_TYPE_PIN6] &&
            (lat2_q[POS_TYPE_PIN6] != p26_drv_prev_q); // [R13]
        // Read: ports give pin levels, latch untouched [R15]
        case (bus_addr_in)
            ADDR_PORT0_DATA: rdata_d = lvl0;
            ADDR_PORT1_DATA: rdata_d = lvl1;
            ADDR_PORT2_DATA: rdata_d = {1'b0, lvl2};
            ADDR_PORT4_DATA: rdata_d = lvl4;
            ADDR_PORT0_DIRECTION: rdata_d = dir0_q;
            ADDR_PORT1_DIRECTION: rdata_d = dir1_q;
            ADDR_PORT2_DIRECTION: rdata_d = dir2_q; // [R19]
            ADDR_PORT4_DIRECTION: rdata_d = dir4_q;
            ADDR_PULLUP_ENABLE: rdata_d = pu_q;
            ADDR_PORT01_OUTPUT_TYPE: rdata_d = ty01_q;
            ADDR_PORT2_PIN_OUTPUT_TYPE: rdata_d = ty2_q;
            ADDR_KEY_RETURN_MODE: rdata_d = krm_q;
            default: rdata_d = 8'h00;
        endcase
        if (!bus_rd_in) begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            lat0_q <= RST_LATCH;
            lat1_q <= RST_LATCH;
            lat2_q <= RST_LATCH;
            lat4_q <= RST_LATCH;
            dir0_q <= RST_DIRECTION; // [R3]
            dir1_q <= RST_DIRECTION; // [R3]
            dir2_q <= RST_DIRECTION; // [R3]
            dir4_q <= RST_DIRECTION; // [R3]
            pu_q <= RST_PULLUP; // [R7]
            ty01_q <= RST_OUTPUT_TYPE; // [R17]
            ty2_q <= RST_OUTPUT_TYPE; // [R17]
            krm_q <= RST_KEY_RETURN;
            drv0_q <= 8'h00;
            drv1_q <= 8'h00;
            drv2_q <= 7'h00;
            drv4_q <= 8'h00;
            oen0_q <= 8'hff;
            oen1_q <= 8'hff;
            oen2_q <= 7'h7f;
            oen4_q <= 8'hff;
            pu_on_q <= '0;
            rdata_q <= 8'h00;
            edge_q <= 1'b0;
            p26_drv_prev_q <= 1'b0;
        end else begin
            lat0_q <= lat0_d;
            lat1_q <= lat1_d;
            lat2_q <= lat2_d;
            lat4_q <= lat4_d;
            dir0_q <= dir0_d;
            dir1_q <= dir1_d;
            dir2_q <= dir2_d;
            dir4_q <= dir4_d;
            pu_q <= pu_d;
            ty01_q <= ty01_d;
            ty2_q <= ty2_d;
            krm_q <= krm_d;
            drv0_q <= drv0_d;
            drv1_q <= drv1_d;
            drv2_q <= drv2_d;
            drv4_q <= drv4_d;
            oen0_q <= oen0_d;
            oen1_q <= oen1_d;
            oen2_q <= oen2_d;
            oen4_q <= oen4_d;
            pu_on_q <= pu_on_d;
            rdata_q <= rdata_d;
            edge_q <= edge_d;
            p26_drv_prev_q <= p26_drv_prev_d;
        end
    end

    assign port0_pin_out = drv0_q;
    assign port1_pin_out = drv1_q;
    assign port2_pin_out = drv2_q;
    assign port4_pin_out = drv4_q;
    assign port0_pin_oe_n_out = oen0_q;
    assign port1_pin_oe_n_out = oen1_q;
    assign port2_pin_oe_n_out = oen2_q;
    assign port4_pin_oe_n_out = oen4_q;
    assign pullup_on_out = pu_on_q;
    assign key_return_mode_enable_out = krm_q[0];
    assign port2_pin6_edge_out = edge_q;
    assign bus_rdata_out = rdata_q;
endmodule // qpio_port_ctrl

/* File: qpio_port_ctrl_monitor.sv */
`timescale 1ns/1ps
module qpio_port_ctrl_monitor
    import qpio_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic [15:0] bus_addr_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire logic [7:0] bus_bit_mask_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic [7:0] bus_rdata_out,
    input wire logic [7:0] port0_pin_out,
    input wire logic [6:0] port2_pin_out,
    input wire logic [7:0] port0_pin_oe_n_out,
    input wire logic [7:0] port1_pin_oe_n_out,
    input wire logic [6:0] port2_pin_oe_n_out,
    input wire logic [7:0] port4_pin_oe_n_out,
    input wire logic [PIN_TOTAL-1:0] pullup_on_out,
    input wire logic key_return_mode_enable_out,
    input wire logic port2_pin6_edge_out
);
    // ========================================
    // Properties
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    logic [PIN_TOTAL-1:0] oe_n_all;
    assign oe_n_all = {port4_pin_oe_n_out, port2_pin_oe_n_out,
        port1_pin_oe_n_out, port0_pin_oe_n_out};
    AST_PULLUP_INPUT_ONLY: assert property (
        (pullup_on_out & ~oe_n_all) == '0)
        else $error("pull-up on a driven pin");
    AST_RESET_INPUT: assert property (
        $past(sys_rst_in) |-> &oe_n_all)
        else $error("pin driven right after reset");
    AST_RESET_PULLUP_OFF: assert property (
        $past(sys_rst_in) |-> pullup_on_out == '0)
        else $error("pull-up on right after reset");
    AST_PORT2_TOP_DIR: assert property (
        bus_rd_in && bus_addr_in == ADDR_PORT2_DIRECTION |=> bus_rdata_out[7])
        else $error("port 2 direction top bit not one");
    AST_DIR_INPUT_RELEASE: assert property (
        (bus_wr_in && bus_addr_in == ADDR_PORT1_DIRECTION
        && bus_bit_mask_in == 8'hff && bus_wdata_in == 8'hff) ##1 !bus_wr_in
        |=> port1_pin_oe_n_out == 8'hff)
        else $error("input direction left driver on");
    AST_EDGE_CAUSE: assert property (
        port2_pin6_edge_out |-> $past(bus_wr_in, 2))
        else $error("edge pulse without a write");
    AST_EDGE_ON_DRIVE: assert property (
        !port2_pin_oe_n_out[6] && $changed(port2_pin_out[6])
        |-> port2_pin6_edge_out)
        else $error("driven pin 6 change gave no edge");
    AST_READ_KEEPS_LATCH: assert property (
        bus_rd_in && !$past(bus_wr_in) |=> $stable(port0_pin_out))
        else $error("read changed the drive value");
    AST_KEY_MODE_SET: assert property (
        (bus_wr_in && bus_addr_in == ADDR_KEY_RETURN_MODE && bus_bit_mask_in[0]
        && bus_wdata_in[0]) ##1 !bus_wr_in |-> ##[0:1] key_return_mode_enable_out)
        else $error("key-return mode not set");
    COV_EDGE: cover property (port2_pin6_edge_out);
    COV_PULLUP: cover property (pullup_on_out[7:0] == 8'hff);
    COV_KEY: cover property (key_return_mode_enable_out);
endmodule // qpio_port_ctrl_monitor

bind qpio_port_ctrl qpio_port_ctrl_monitor i_mon (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .bus_addr_in(bus_addr_in),
    .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
    .bus_bit_mask_in(bus_bit_mask_in), .bus_wdata_in(bus_wdata_in),
    .bus_rdata_out(bus_rdata_out), .port0_pin_out(port0_pin_out),
    .port2_pin_out(port2_pin_out),
    .port0_pin_oe_n_out(port0_pin_oe_n_out),
    .port1_pin_oe_n_out(port1_pin_oe_n_out),
    .port2_pin_oe_n_out(port2_pin_oe_n_out),
    .port4_pin_oe_n_out(port4_pin_oe_n_out), .pullup_on_out(pullup_on_out),
    .key_return_mode_enable_out(key_return_mode_enable_out),
    .port2_pin6_edge_out(port2_pin6_edge_out)
);

/* File: qpio_pin_model.sv */
`timescale 1ns/1ps
module qpio_pin_model #(
    parameter int W = 8
) (
    input wire logic clock_in,
    input wire logic [W-1:0] drv_in,
    input wire logic [W-1:0] oe_n_in,
    input wire logic [W-1:0] pull_in,
    input wire logic [W-1:0] ext_en_in,
    input wire logic [W-1:0] ext_val_in,
    output logic [W-1:0] level_out
);
    // ========================================
    // Wire level: own drive, outside drive, pull-up, else wandering
    logic [W-1:0] float_q = '0;
    always_ff @(posedge clock_in) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!oe_n_in[i]) begin
                level_out[i] = drv_in[i];
            end else if (ext_en_in[i]) begin
                level_out[i] = ext_val_in[i];
            end else if (pull_in[i]) begin
                level_out[i] = 1'b1;
            end else begin
                level_out[i] = float_q[i];
            end
        end
    end
endmodule // qpio_pin_model

/* File: quad_port_io_control_tb_top.sv */
`timescale 1ns/1ps
module quad_port_io_control_tb_top;
    import qpio_pkg::*;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] mask = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, p0i, p1i, p4i, p0o, p1o, p4o, p0e, p1e, p4e;
    logic [6:0] p2i, p2o, p2e;
    logic [PIN_TOTAL-1:0] pu;
    logic krm, edg;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_lo_en = 8'h00;
    logic [7:0] ext_lo_val = 8'h00;
    int err_count = 0;
    int check_count = 0;
    logic [15:0] raddr [7] = '{ADDR_PORT0_DIRECTION, ADDR_PORT1_DIRECTION,
        ADDR_PORT2_DIRECTION, ADDR_PORT4_DIRECTION, ADDR_PULLUP_ENABLE,
        ADDR_PORT01_OUTPUT_TYPE, ADDR_PORT2_PIN_OUTPUT_TYPE};
    logic [7:0] rrst [7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    initial begin
        forever #2 clock_in = ~clock_in;
    end
    qpio_port_ctrl i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .bus_addr_in(addr), .bus_wr_in(wr), .bus_rd_in(rd),
        .bus_bit_mask_in(mask), .bus_wdata_in(wdata), .bus_rdata_out(rdata),
        .port0_pin_in(p0i), .port1_pin_in(p1i), .port2_pin_in(p2i),
        .port4_pin_in(p4i), .port0_pin_out(p0o), .port1_pin_out(p1o),
        .port2_pin_out(p2o), .port4_pin_out(p4o), .port0_pin_oe_n_out(p0e),
        .port1_pin_oe_n_out(p1e), .port2_pin_oe_n_out(p2e),
        .port4_pin_oe_n_out(p4e), .pullup_on_out(pu),
        .key_return_mode_enable_out(krm), .port2_pin6_edge_out(edg));
    qpio_pin_model #(.W(8)) i_pin0 (.clock_in(clock_in), .drv_in(p0o),
        .oe_n_in(p0e), .pull_in(pu[7:0]), .ext_en_in(ext_lo_en),
        .ext_val_in(ext_lo_val), .level_out(p0i));
    qpio_pin_model #(.W(8)) i_pin1 (.clock_in(clock_in), .drv_in(p1o),
        .oe_n_in(p1e), .pull_in(pu[15:8]), .ext_en_in(ext_lo_en),
        .ext_val_in(ext_lo_val), .level_out(p1i));
    qpio_pin_model #(.W(7)) i_pin2 (.clock_in(clock_in), .drv_in(p2o),
        .oe_n_in(p2e), .pull_in(pu[22:16]), .ext_en_in(ext_lo_en[6:0]),
        .ext_val_in(ext_lo_val[6:0]), .level_out(p2i));
    qpio_pin_model #(.W(8)) i_pin4 (.clock_in(clock_in), .drv_in(p4o),
        .oe_n_in(p4e), .pull_in(pu[30:23]), .ext_en_in(ext_en),
        .ext_val_in(ext_val), .level_out(p4i));
    // ========================================
    // Bus tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] m,
                          input logic [7:0] d);
        @(negedge clock_in);
        addr = a;
        mask = m;
        wdata = d;
        wr = 1'b1;
        @(negedge clock_in);
        wr = 1'b0;
        @(negedge clock_in);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clock_in);
        addr = a;
        rd = 1'b1;
        @(negedge clock_in);
        rd = 1'b0;
        chk(rdata, exp);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clock_in);
        @(negedge clock_in);
        sys_rst_in = 1'b0;
        foreach (raddr[i]) rd_chk(raddr[i], rrst[i]);
        chk({1'b1, p2e} & p4e, 8'hff);
        chk(pu[30:23], 8'h00);
        wr_reg(16'hff10, 8'hff, 8'hff);
        rd_chk(16'hff10, 8'h00);
        wr_reg(ADDR_PORT2_DIRECTION, 8'hff, 8'h00);
        rd_chk(ADDR_PORT2_DIRECTION, 8'h80);
        wr_reg(ADDR_PORT2_DIRECTION, 8'hff, 8'hff);
        wr_reg(ADDR_PULLUP_ENABLE, 8'hff, 8'h17);
        rd_chk(ADDR_PULLUP_ENABLE, 8'h17);
        chk(pu[7:0] & pu[30:23], 8'hff);
        wr_reg(ADDR_PORT0_DIRECTION, 8'h08, 8'h00);
        rd_chk(ADDR_PORT0_DIRECTION, 8'hf7);
        chk(pu[7:0], 8'hf7);
        repeat (6) @(negedge clock_in);
        rd_chk(ADDR_PORT1_DATA, 8'hff);
        wr_reg(ADDR_PORT0_DATA, 8'hff, 8'h5a);
        chk(p0e, 8'hf7);
        chk(p0o & ~p0e, 8'h08);
        wr_reg(ADDR_PORT0_DIRECTION, 8'hff, 8'h00);
        chk(p0e, 8'h00);
        chk(p0o, 8'h5a);
        repeat (6) @(negedge clock_in);
        rd_chk(ADDR_PORT0_DATA, 8'h5a);
        chk(p0o, 8'h5a);
        chk(pu[7:0], 8'h00);
        wr_reg(ADDR_PORT01_OUTPUT_TYPE, 8'h01, 8'h01);
        chk(p0e, 8'h5a);
        chk(p0o & ~p0e, 8'h00);
        wr_reg(ADDR_PORT01_OUTPUT_TYPE, 8'h02, 8'h02);
        wr_reg(ADDR_PORT1_DATA, 8'hff, 8'h0f);
        wr_reg(ADDR_PORT1_DIRECTION, 8'hff, 8'h00);
        chk(p1e, 8'h0f);
        chk(p1o, 8'h0f);
        rd_chk(ADDR_PORT01_OUTPUT_TYPE, 8'h03);
        wr_reg(ADDR_PORT1_DIRECTION, 8'hff, 8'hff);
        chk(p1e, 8'hff);
        wr_reg(ADDR_PORT2_PIN_OUTPUT_TYPE, 8'hff, 8'hff);
        rd_chk(ADDR_PORT2_PIN_OUTPUT_TYPE, 8'h60);
        wr_reg(ADDR_PORT2_PIN_OUTPUT_TYPE, 8'hff, 8'h00);
        wr_reg(ADDR_PORT2_DIRECTION, 8'h40, 8'h00);
        wr_reg(ADDR_PORT2_DATA, 8'h40, 8'h40);
        chk({7'h00, edg}, 8'h01);
        chk({1'b0, p2o} & 8'h40, 8'h40);
        chk({1'b0, p2e}, 8'h3f);
        repeat (2) @(negedge clock_in);
        chk({7'h00, edg}, 8'h00);
        wr_reg(ADDR_KEY_RETURN_MODE, 8'h01, 8'h01);
        chk({7'h00, krm}, 8'h01);
        wr_reg(ADDR_PORT4_DATA, 8'hff, 8'h3c);
        chk(p4o, 8'h3c);
        chk(p4e, 8'hff);
        ext_en = 8'hff;
        ext_val = 8'ha5;
        repeat (6) @(negedge clock_in);
        rd_chk(ADDR_PORT4_DATA, 8'ha5);
        // Port 2 pin 6 as plain input, driven low from outside; no edge raised
        wr_reg(ADDR_PORT2_DIRECTION, 8'h40, 8'h40);
        ext_lo_en = 8'h40;
        repeat (6) @(negedge clock_in);
        rd_chk(ADDR_PORT2_DATA, 8'h3f);
        chk({7'h00, edg}, 8'h00);
        finish_test();
    end
endmodule // quad_port_io_control_tb_top
